/* hw/ccsc_core.sv */
// Purpose: execution and status/control core of a 16-bit cpu
// Assumes: issued ops and exception requests come from the same clock
// Notes: one op per cycle unless busy_q; exceptions win over an op
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module ccsc_core
   import ccsc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [5:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata_q,
   // instruction issue
   input  wire logic        op_valid,
   input  wire ccsc_op_s    op,
   input  wire logic [15:0] mem_rdata,
   output logic             busy_q,
   output logic             res_valid_q,
   output logic [15:0]      res_q,
   output logic [22:0]      ip_q,
   // stack writes
   output logic             stack_wr_q,
   output logic [15:0]      stack_addr_q,
   output logic [15:0]      stack_data_q,
   // exceptions
   input  wire logic        exc_req,
   input  wire logic [6:0]  exc_src,
   input  wire logic [2:0]  exc_prio,
   input  wire logic        nesting_disable,
   output logic             exc_ack_q,
   output logic [6:0]       vector_q,
   output logic [3:0]       level_q,
   output logic             irq_off_q,
   // data space visibility
   input  wire logic        data_req,
   input  wire logic [15:0] data_addr,
   output logic             vis_req_q,
   output logic [22:0]      vis_addr_q
);

   // state
   logic [15:0] wreg_q [16];
   logic [15:0] loop_q;
   logic [7:0]  page_q;
   logic        ra_q;
   logic        dc_q;
   logic        n_q;
   logic        ov_q;
   logic        z_q;
   logic        c_q;
   logic [2:0]  ipl_q;
   logic        priority_level_top_bit_q;
   logic        psv_q;
   logic        multi_q;
   ccsc_op_s    save_q;
   logic        div_busy;
   logic        div_done;
   logic [15:0] div_quot;
   logic [15:0] div_rem;

   // alu with byte and word flag rules
   function automatic ccsc_alu_s alu_eval(input ccsc_op_e    f,
                                          input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic        bm);
      logic [15:0] bx;
      logic        ci;
      logic [4:0]  s4;
      logic [8:0]  s8;
      logic [16:0] s16;
      logic [15:0] r;
      logic        am;
      logic        bmsb;
      logic        rm;
      ccsc_alu_s   o;
      bx  = (f == OP_SUB) ? ~b : b;
      ci  = (f == OP_SUB);
      s4  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
      s8  = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, ci};
      s16 = {1'b0, a} + {1'b0, bx} + {16'h0000, ci};
      r   = (f == OP_AND) ? (a & b) :
            (f == OP_IOR) ? (a | b) :
            (f == OP_XOR) ? (a ^ b) : s16[15:0];
      if (bm) r = {a[15:8], r[7:0]};
      am   = bm ? a[7] : a[15];
      bmsb = bm ? bx[7] : bx[15];
      rm   = bm ? r[7] : r[15];
      o.res = r;
      o.c   = bm ? s8[8] : s16[16];
      o.dc  = bm ? s4[4] : s8[8];
      o.ov  = (am == bmsb) && (rm != am);
      o.n   = rm;
      o.z   = bm ? (r[7:0] == 8'h00) : (r == 16'h0000);
      return o;
   endfunction : alu_eval

   // operand fetch from the register array or data memory
   wire [15:0] opa   = wreg_q[op.rs1];
   wire [15:0] opb   = op.src_mem ? mem_rdata : wreg_q[op.rs2];
   wire [3:0]  rd1   = 4'(op.rd + 4'h1);
   wire [3:0]  rs11  = 4'(op.rs1 + 4'h1);
   wire [3:0]  srd1  = 4'(save_q.rd + 4'h1);
   wire [3:0]  srs11 = 4'(save_q.rs1 + 4'h1);
   wire [15:0] sp    = wreg_q[SP_IDX];
   wire ccsc_alu_s alu = alu_eval(op.op, opa, opb, op.byte_m);

   // operation classes
   wire is_arith = (op.op == OP_ADD) || (op.op == OP_SUB);
   wire is_logic = (op.op == OP_AND) || (op.op == OP_IOR) ||
                   (op.op == OP_XOR);
   wire is_alu   = is_arith || is_logic;
   wire is_multi = (op.op == OP_CALL) || (op.op == OP_GOTO) ||
                   (op.op == OP_MOVD);
   wire s_branch = (save_q.op == OP_CALL) || (save_q.op == OP_GOTO);
   wire s_call   = multi_q && (save_q.op == OP_CALL);
   wire s_movd   = multi_q && (save_q.op == OP_MOVD);

   // exception acceptance: traps outside the second cycle of a long op, interrupts above level
   wire irq_off  = priority_level_top_bit_q || (ipl_q == TOP_PRIO);
   wire is_trap  = exc_src < TRAP_SRCS;
   wire is_irq   = !is_trap && (exc_src < 7'(TRAP_SRCS + IRQ_SRCS)) &&
                   !irq_off && (exc_prio > ipl_q);
   wire exc_take = exc_req && !multi_q && (is_trap || is_irq);
   wire take     = op_valid && !busy_q && !exc_take;
   wire [22:0] vec_ip = {14'h0000, exc_src, 2'b00};

   // repeat loop: pointer holds while iterations remain
   wire repeating = ra_q && (loop_q != 16'h0000);
   wire [22:0] ipn    = 23'(ip_q + IP_STEP);
   wire [22:0] target = {6'h00, save_q.imm, 1'b0};

   // multiplier operand extension per sign mode
   wire ma_s = !op.byte_m && ((op.mode == 2'd0) || (op.mode == 2'd3));
   wire mb_s = !op.byte_m && ((op.mode == 2'd0) || (op.mode == 2'd2));
   wire [16:0] ma = op.byte_m ? {9'h000, opa[7:0]} : {ma_s & opa[15], opa};
   wire [16:0] mb = op.byte_m ? {9'h000, opb[7:0]} : {mb_s & opb[15], opb};
   wire signed [33:0] prod = $signed(ma) * $signed(mb);

   // divider operands: wide pair or one extended word
   wire        dv_s   = op.mode[0];
   wire        dv_w   = op.mode[1];
   wire [31:0] dv_end = dv_w ? {wreg_q[rs11], opa} :
                        {{16{dv_s & opa[15]}}, opa};
   wire        div_start = take && (op.op == OP_DIV);

   // primary write port
   wire we_a = div_done || s_movd ||
               (take && (is_alu || op.op == OP_MOV ||
                         op.op == OP_MUL || op.op == OP_MOVD));
   wire [3:0] wa_a = div_done ? 4'h0 : s_movd ? srd1 : op.rd;
   wire [15:0] wd_a = div_done ? div_quot :
                      s_movd ? wreg_q[srs11] :
                      (op.op == OP_MUL) ? prod[15:0] :
                      (op.op == OP_MOVD) ? opa :
                      (op.op == OP_MOV) ? opb : alu.res;

   // second write port: product high word or remainder
   wire        we_b = div_done || (take && op.op == OP_MUL);
   wire [3:0]  wa_b = div_done ? 4'h1 : rd1;
   wire [15:0] wd_b = div_done ? div_rem : prod[31:16];

   // stack pushes through the stack pointer register
   wire push = exc_take || s_call ||
               (take && (op.op == OP_PUSH || op.op == OP_CALL));
   wire [15:0] push_d = exc_take ? ip_q[15:0] :
                        s_call ? {9'h000, ipn[22:16]} :
                        (op.op == OP_PUSH) ? opa : ipn[15:0];

   // pointer next value
   wire [22:0] ip_d = exc_take ? vec_ip :
                      (multi_q && s_branch) ? target :
                      (take && op.op != OP_CALL && op.op != OP_GOTO &&
                       !repeating) ? ipn : ip_q;

   // priority bits and clear-only top bit; hardware set wins
   wire st_wr  = reg_wr && (reg_addr == REG_STATUS);
   wire ctl_wr = reg_wr && (reg_addr == REG_CONTROL);
   wire [2:0] ipl_d = (exc_take && !is_trap) ? exc_prio :
                      (st_wr && !nesting_disable) ?
                      reg_wdata[ST_IPL +: 3] : ipl_q;
   wire priority_level_top_bit_d = (exc_take && is_trap) ||
                 (priority_level_top_bit_q && !(ctl_wr && !reg_wdata[CTL_PRIORITY_LEVEL_TOP_BIT]));

   // register read view, unused bits tied low
   wire [15:0] status_w  = {7'h00, dc_q, ipl_q, ra_q,
                            n_q, ov_q, z_q, c_q};
   wire [15:0] control_w = {12'h000, priority_level_top_bit_q, psv_q, 2'b00};
   wire [15:0] rd_mux =
      (reg_addr == REG_STATUS)  ? status_w :
      (reg_addr == REG_CONTROL) ? control_w :
      (reg_addr == REG_IP_LO)   ? ip_q[15:0] :
      (reg_addr == REG_IP_HI)   ? {9'h000, ip_q[22:16]} :
      (reg_addr == REG_PAGE)    ? {8'h00, page_q} :
      (reg_addr == REG_LOOP)    ? loop_q :
      (reg_addr[5:4] == REG_WREG_HI) ? wreg_q[reg_addr[3:0]] : 16'h0000;

   // divider engine
   ccsc_divider u_div (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .start    (div_start),
      .abort    (exc_take),
      .signed_m (dv_s),
      .dividend (dv_end),
      .divisor  (opb),
      .busy_q   (div_busy),
      .done_q   (div_done),
      .quot_q   (div_quot),
      .rem_q    (div_rem)
   );

   // working register array; later writes take precedence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 16; i++) wreg_q[i] <= WREG_RST;
      end else begin
         if (reg_wr && reg_addr[5:4] == REG_WREG_HI)
            wreg_q[reg_addr[3:0]] <= reg_wdata;
         if (we_a) wreg_q[wa_a] <= wd_a;
         if (we_b) wreg_q[wa_b] <= wd_b;
         if (push) wreg_q[SP_IDX] <= 16'(sp + 16'h0002);
      end
   end

   // sequencing: second cycle of long ops and divide occupancy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         multi_q <= 1'b0;
         save_q  <= '0;
         busy_q  <= 1'b0;
         ip_q    <= IP_RST;
      end else begin
         multi_q <= take && is_multi;
         if (take) save_q <= op;
         busy_q  <= (take && is_multi) || div_start || div_busy;
         ip_q    <= ip_d;
      end
   end

   // repeat loop counter and active flag
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         loop_q <= LOOP_RST;
         ra_q   <= 1'b0;
      end else if (take && op.op == OP_RPT) begin
         loop_q <= op.imm;
         ra_q   <= 1'b1;
      end else if (exc_take) begin
         ra_q   <= 1'b0;
      end else if (take && ra_q) begin
         if (loop_q == 16'h0000) ra_q <= 1'b0;
         else loop_q <= 16'(loop_q - 16'h0001);
      end else if (reg_wr && reg_addr == REG_LOOP) begin
         loop_q <= reg_wdata;
      end
   end

   // arithmetic flags; an operation wins over a software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {dc_q, n_q, ov_q, z_q, c_q} <= 5'h00;
      end else if (take && is_alu) begin
         n_q <= alu.n;
         z_q <= alu.z;
         if (is_arith) begin
            c_q  <= alu.c;
            dc_q <= alu.dc;
            ov_q <= alu.ov;
         end
      end else if (st_wr) begin
         dc_q <= reg_wdata[ST_DC];
         n_q  <= reg_wdata[ST_N];
         ov_q <= reg_wdata[ST_OV];
         z_q  <= reg_wdata[ST_Z];
         c_q  <= reg_wdata[ST_C];
      end
   end

   // priority, control word and visibility page
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ipl_q     <= 3'h0;
         priority_level_top_bit_q    <= 1'b0;
         psv_q     <= 1'b0;
         page_q    <= PAGE_RST;
         level_q   <= 4'h0;
         irq_off_q <= 1'b0;
      end else begin
         ipl_q     <= ipl_d;
         priority_level_top_bit_q    <= priority_level_top_bit_d;
         if (ctl_wr) psv_q <= reg_wdata[CTL_PSV];
         if (reg_wr && reg_addr == REG_PAGE) page_q <= reg_wdata[7:0];
         level_q   <= {priority_level_top_bit_d, ipl_d};
         irq_off_q <= priority_level_top_bit_d || (ipl_d == TOP_PRIO);
      end
   end

   // exception, stack and result reporting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         exc_ack_q    <= 1'b0;
         vector_q     <= 7'h00;
         stack_wr_q   <= 1'b0;
         stack_addr_q <= 16'h0000;
         stack_data_q <= 16'h0000;
         res_valid_q  <= 1'b0;
         res_q        <= 16'h0000;
      end else begin
         exc_ack_q    <= exc_take;
         if (exc_take) vector_q <= exc_src;
         stack_wr_q   <= push;
         if (push) stack_addr_q <= sp;
         if (push) stack_data_q <= push_d;
         res_valid_q  <= we_a;
         if (we_a) res_q <= wd_a;
      end
   end

   // program space visibility window and register read data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         vis_req_q   <= 1'b0;
         vis_addr_q  <= 23'h000000;
         reg_rdata_q <= 16'h0000;
      end else begin
         vis_req_q   <= data_req && psv_q && data_addr[VIS_BIT];
         vis_addr_q  <= {page_q, data_addr[14:0]};
         reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
      end
   end

endmodule : ccsc_core

/* hw/ccsc_pkg.sv */
// Purpose: shared constants and types of the cpu status/control core
// Assumes: one clock, synchronous active-high reset
// Notes: register indices are word indices on the plain register port
package ccsc_pkg;

   // datapath sizes and fixed register roles
   localparam int          PAGE_W  = 8;
   localparam logic [3:0]  SP_IDX  = 4'hF;
   localparam logic [22:0] IP_STEP = 23'h000002;
   localparam logic [22:0] IP_RST  = 23'h000000;

   // exception source counts and top user priority
   localparam logic [6:0] TRAP_SRCS = 7'h08;
   localparam logic [6:0] IRQ_SRCS  = 7'h76;
   localparam logic [2:0] TOP_PRIO  = 3'h7;

   // divider timing in clock cycles, start cycle included
   localparam logic [4:0] DIV_CYCLES = 5'h13;
   localparam logic [4:0] DIV_STEPS  = 5'h10;

   // register indices
   localparam logic [5:0] REG_STATUS  = 6'h00;
   localparam logic [5:0] REG_CONTROL = 6'h01;
   localparam logic [5:0] REG_IP_LO   = 6'h02;
   localparam logic [5:0] REG_IP_HI   = 6'h03;
   localparam logic [5:0] REG_PAGE    = 6'h04;
   localparam logic [5:0] REG_LOOP    = 6'h05;
   localparam logic [1:0] REG_WREG_HI = 2'h1;

   // status and control bit positions
   localparam int ST_C     = 0;
   localparam int ST_Z     = 1;
   localparam int ST_OV    = 2;
   localparam int ST_N     = 3;
   localparam int ST_IPL   = 5;
   localparam int ST_DC    = 8;
   localparam int CTL_PSV  = 2;
   localparam int CTL_PRIORITY_LEVEL_TOP_BIT = 3;
   localparam int VIS_BIT  = 15;

   // reset values
   localparam logic [15:0] WREG_RST = 16'h0000;
   localparam logic [15:0] LOOP_RST = 16'h0000;
   localparam logic [7:0]  PAGE_RST = 8'h00;

   // operations issued to the core
   typedef enum logic [3:0] {
      OP_NOP  = 4'h0, OP_ADD  = 4'h1, OP_SUB  = 4'h2, OP_AND = 4'h3,
      OP_IOR  = 4'h4, OP_XOR  = 4'h5, OP_MOV  = 4'h6, OP_MUL = 4'h7,
      OP_DIV  = 4'h8, OP_RPT  = 4'h9, OP_PUSH = 4'hA, OP_CALL = 4'hB,
      OP_GOTO = 4'hC, OP_MOVD = 4'hD
   } ccsc_op_e;

   // one issued instruction
   typedef struct packed {
      ccsc_op_e    op;
      logic [3:0]  rd;
      logic [3:0]  rs1;
      logic [3:0]  rs2;
      logic        byte_m;
      logic        src_mem;
      logic [1:0]  mode;
      logic [15:0] imm;
   } ccsc_op_s;

   // alu result with flags
   typedef struct packed {
      logic [15:0] res;
      logic        c;
      logic        dc;
      logic        ov;
      logic        n;
      logic        z;
   } ccsc_alu_s;

endpackage : ccsc_pkg

/* hw/ccsc_divider.sv */
// Purpose: iterative non-restoring 32/16 and 16/16 divider
// Assumes: dividend already sign or zero extended to 32 bits
// Notes: abort drops the operation, results are then not written
`timescale 1ns/1ps
module ccsc_divider
   import ccsc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // control
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic        signed_m,
   // operands
   input  wire logic [31:0] dividend,
   input  wire logic [15:0] divisor,
   // status and results
   output logic             busy_q,
   output logic             done_q,
   output logic [15:0]      quot_q,
   output logic [15:0]      rem_q
);

   logic [4:0]  cnt_q;
   logic [17:0] r_q;
   logic [15:0] q_q;
   logic [17:0] d_q;
   logic        negq_q;
   logic        negr_q;

   // operand magnitudes and one non-restoring step
   wire         a_neg = signed_m & dividend[31];
   wire         b_neg = signed_m & divisor[15];
   wire [31:0]  a_mag = a_neg ? 32'(-dividend) : dividend;
   wire [15:0]  b_mag = b_neg ? 16'(-divisor) : divisor;
   wire [17:0]  r_sh  = {r_q[16:0], q_q[15]};
   wire [17:0]  r_nx  = r_q[17] ? 18'(r_sh + d_q) : 18'(r_sh - d_q);
   wire [17:0]  r_cor = r_q[17] ? 18'(r_q + d_q) : r_q;
   wire [15:0]  r_fix = r_cor[15:0];

   // one cycle load, sixteen steps, then corrected and signed result
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q  <= 5'h00;
         r_q    <= 18'h00000;
         q_q    <= 16'h0000;
         d_q    <= 18'h00000;
         negq_q <= 1'b0;
         negr_q <= 1'b0;
         quot_q <= 16'h0000;
         rem_q  <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= 5'h01;
            r_q    <= {2'b00, a_mag[31:16]};
            q_q    <= a_mag[15:0];
            d_q    <= {2'b00, b_mag};
            negq_q <= a_neg ^ b_neg;
            negr_q <= a_neg;
         end else if (busy_q && abort) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= 5'(cnt_q + 5'h01);
            if (cnt_q <= DIV_STEPS) begin
               r_q <= r_nx;
               q_q <= {q_q[14:0], ~r_nx[17]};
            end else begin
               // remainder fix-up shares this step to keep 19 cycles
               busy_q <= 1'b0;
               done_q <= 1'b1;
               quot_q <= negq_q ? 16'(-q_q) : q_q;
               rem_q  <= negr_q ? 16'(-r_fix) : r_fix;
            end
         end
      end
   end

endmodule : ccsc_divider

/* verif/ccsc_props.sv */
// Purpose: port checks of the status/control core
// Assumes: one clock, sync active-high reset
// Notes: bound onto ccsc_core
`timescale 1ns/1ps
module ccsc_props
   import ccsc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // register port
   input wire logic [5:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata_q,
   // issue and exceptions
   input wire logic        op_valid,
   input wire ccsc_op_s    op,
   input wire logic        busy_q,
   input wire logic        res_valid_q,
   input wire logic [22:0] ip_q,
   input wire logic        exc_req,
   input wire logic [6:0]  exc_src,
   input wire logic        exc_ack_q,
   input wire logic        stack_wr_q,
   input wire logic [3:0]  level_q,
   input wire logic        irq_off_q,
   // visibility
   input wire logic        data_req,
   input wire logic [15:0] data_addr,
   input wire logic        vis_req_q
);
   // op accepted this cycle with no exception request
   wire take = op_valid && !busy_q && !exc_req;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_status_top: assert property (
      $past(reg_rd && reg_addr == REG_STATUS) |-> reg_rdata_q[15:9] == 7'h00)
      else $error("status top bits not zero");
   a_ctl_unused: assert property (
      $past(reg_rd && reg_addr == REG_CONTROL)
      |-> (reg_rdata_q & 16'hFFF3) == 16'h0000)
      else $error("control unused bits not zero");
   a_level_off: assert property (
      irq_off_q == (level_q[3] | (level_q[2:0] == TOP_PRIO)))
      else $error("irq off disagrees with level");
   a_vis_hit: assert property (
      vis_req_q |-> $past(data_req && data_addr[15]))
      else $error("window hit without upper access");
   a_add_single: assert property (
      take && op.op == OP_ADD |=> res_valid_q && !busy_q)
      else $error("add not single cycle");
   a_mul_single: assert property (
      take && op.op == OP_MUL |=> res_valid_q)
      else $error("multiply not single cycle");
   a_div_time: assert property (
      take && op.op == OP_DIV |=> (!res_valid_q)[*8] ##11 res_valid_q)
      else $error("divide length wrong");
   a_goto_ip: assert property (
      take && op.op == OP_GOTO |=> busy_q ##1
      (!busy_q && ip_q == {6'h00, $past(op.imm, 2), 1'h0}))
      else $error("branch target wrong");
   a_trap_take: assert property (
      exc_req && exc_src < TRAP_SRCS && !busy_q |=> exc_ack_q
      && stack_wr_q && ip_q == {14'h0000, $past(exc_src), 2'h0})
      else $error("trap not taken");
endmodule : ccsc_props
bind ccsc_core ccsc_props u_props (.*);

/* verif/testbench.sv */
// Purpose: self-checking bench for the status/control core
// Assumes: 200 MHz clock, reset held two cycles
// Notes: operand b always comes from mem_rdata
`timescale 1ns/1ps
module testbench;
   import ccsc_pkg::*;
   logic        clk, sys_rst, reg_wr, reg_rd, op_valid, exc_req;
   logic        nesting_disable, data_req, busy_q, res_valid_q;
   logic        stack_wr_q, exc_ack_q, irq_off_q, vis_req_q;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata_q, mem_rdata, res_q, data_addr;
   logic [15:0] stack_addr_q, stack_data_q, v;
   logic [22:0] ip_q, vis_addr_q, ip0;
   logic [6:0]  exc_src, vector_q;
   logic [3:0]  level_q;
   logic [2:0]  exc_prio;
   ccsc_op_s    op;
   int          num_errors, checks, cyc;
   ccsc_core uut (.*);
   task chk(input logic [22:0] g, input logic [22:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task rc(input logic [5:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 v = reg_rdata_q;
      chk(v, e);
   endtask : rc
   task issue(input ccsc_op_e o, input logic [3:0] d, input logic bm,
              input logic [1:0] md, input logic [15:0] im, b);
      @(posedge clk);
      op        <= '{o, d, 4'h1, 4'h0, bm, 1'h1, md, im};
      mem_rdata <= b;
      op_valid  <= 1'h1;
      @(posedge clk);
      op_valid <= 1'h0;
      #1;
   endtask : issue
   task exc(input logic [6:0] s, input logic [2:0] p, input logic e);
      @(posedge clk);
      exc_req  <= 1'h1;
      exc_src  <= s;
      exc_prio <= p;
      @(posedge clk);
      exc_req <= 1'h0;
      #1 chk(exc_ack_q, e);
   endtask : exc
   task acc(input logic [15:0] a, input logic e);
      @(posedge clk);
      data_req  <= 1'h1;
      data_addr <= a;
      @(posedge clk);
      data_req <= 1'h0;
      #1 chk(vis_req_q, e);
   endtask : acc
   task t_regs;
      rc(REG_STATUS, 16'h0000);
      rc(REG_CONTROL, 16'h0000);
      rc(6'h3F, 16'h0000);
      wr(REG_STATUS, 16'hFFFF);
      rc(REG_STATUS, 16'h01EF);
      chk(irq_off_q, 1'h1);
      @(posedge clk) nesting_disable <= 1'h1;
      wr(REG_STATUS, 16'h0000);
      rc(REG_STATUS, 16'h00E0);
      @(posedge clk) nesting_disable <= 1'h0;
      wr(REG_STATUS, 16'h0000);
      rc(REG_STATUS, 16'h0000);
      chk(level_q, 4'h0);
      wr(REG_CONTROL, 16'hFFFF);
      rc(REG_CONTROL, 16'h0004);
   endtask : t_regs
   task t_exc;
      wr(6'h1F, 16'h0800);
      #1 ip0 = ip_q;
      exc(7'h03, 3'h0, 1'h1);
      chk(vector_q, 7'h03);
      chk(stack_addr_q, 16'h0800);
      chk(stack_data_q, ip0[15:0]);
      chk(level_q, 4'h8);
      rc(REG_CONTROL, 16'h000C);
      rc(6'h1F, 16'h0802);
      exc(7'h14, 3'h5, 1'h0);
      wr(REG_CONTROL, 16'h0004);
      rc(REG_CONTROL, 16'h0004);
      exc(7'h14, 3'h5, 1'h1);
      chk(level_q, 4'h5);
      exc(7'h15, 3'h5, 1'h0);
   endtask : t_exc
   task t_vis;
      wr(REG_PAGE, 16'h005A);
      acc(16'h0123, 1'h0);
      acc(16'h8123, 1'h1);
      chk(vis_addr_q, {8'h5A, 15'h0123});
      wr(REG_CONTROL, 16'h0000);
      acc(16'h8123, 1'h0);
   endtask : t_vis
   task automatic t_alu;
      ccsc_op_e    o [4] = '{OP_ADD, OP_ADD, OP_SUB, OP_ADD};
      logic [15:0] a [4] = '{16'h7FFF, 16'hFFFF, 16'h0005, 16'h000F};
      logic [15:0] b [4] = '{16'h0001, 16'h0001, 16'h0005, 16'h0001};
      logic [15:0] r [4] = '{16'h8000, 16'h0000, 16'h0000, 16'h0010};
      logic [15:0] f [4] = '{16'h010C, 16'h0103, 16'h0103, 16'h0100};
      for (int i = 0; i < 4; i++) begin
         wr(6'h11, a[i]);
         issue(o[i], 4'h3, i == 3, 2'h0, 16'h0000, b[i]);
         chk(res_valid_q, 1'h1);
         chk(res_q, r[i]);
         rc(REG_STATUS, f[i] | 16'h00A0);
         chk(v & 16'h011F, f[i]);
      end
   endtask : t_alu
   task automatic t_mul;
      logic [15:0] h [4] = '{16'hFFFF, 16'h0001, 16'h0001, 16'hFFFF};
      wr(6'h11, 16'hFFFF);
      for (int m = 0; m < 4; m++) begin
         issue(OP_MUL, 4'h4, 1'h0, m[1:0], 16'h0000, 16'h0002);
         chk(res_q, 16'hFFFE);
         rc(6'h15, h[m]);
      end
      issue(OP_MUL, 4'h4, 1'h1, 2'h0, 16'h0000, 16'h00FF);
      chk(res_q, 16'hFE01);
   endtask : t_mul
   task automatic t_div;
      logic [1:0]  md [3] = '{2'h0, 2'h1, 2'h3};
      logic [15:0] q [3] = '{16'h2484, 16'hFFF2, 16'hFFF2};
      logic [15:0] s [3] = '{16'h0000, 16'hFFFE, 16'hFFFE};
      int          n;
      for (int i = 0; i < 3; i++) begin
         wr(6'h11, 16'hFF9C);
         wr(6'h12, 16'hFFFF);
         issue(OP_DIV, 4'h0, 1'h0, md[i], 16'h0000, 16'h0007);
         for (n = 1; res_valid_q !== 1'h1 && n < 40; n++) begin
            @(posedge clk);
            #1;
         end
         chk(n[22:0], 23'(DIV_CYCLES));
         rc(6'h10, q[i]);
         rc(6'h11, s[i]);
      end
   endtask : t_div
   task t_goto;
      issue(OP_GOTO, 4'h0, 1'h0, 2'h0, 16'h0123, 16'h0000);
      chk(busy_q, 1'h1);
      @(posedge clk);
      #1 chk(ip_q, 23'h000246);
      rc(REG_IP_LO, 16'h0246);
   endtask : t_goto
   task t_rpt;
      issue(OP_RPT, 4'h0, 1'h0, 2'h0, 16'h0002, 16'h0000);
      ip0 = ip_q;
      rc(REG_STATUS, 16'h01B0);
      issue(OP_MOV, 4'h6, 1'h0, 2'h0, 16'h0000, 16'h1234);
      chk(res_q, 16'h1234);
      chk(ip_q, ip0);
      exc(7'h20, 3'h6, 1'h1);
      rc(REG_STATUS, 16'h01C0);
      rc(REG_LOOP, 16'h0001);
   endtask : t_rpt
   task wrap_up;
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // free-running clock
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up;
      end
   end
   // reset then scenarios
   initial begin
      sys_rst = 1'h1;
      {reg_wr, reg_rd, op_valid, exc_req, nesting_disable, data_req} = '0;
      {reg_addr, reg_wdata, mem_rdata, data_addr, exc_src, exc_prio} = '0;
      op = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      t_regs;
      t_exc;
      t_vis;
      t_alu;
      t_mul;
      t_div;
      t_goto;
      t_rpt;
      wrap_up;
   end
endmodule : testbench
